//--- core_fetch_regs.svh
/*
  Constants of the fetch and pipeline sequencer: vectors, widths, sizes.
  Assumes inclusion by bare name from the package and the sequencer.
*/
`ifndef CORE_FETCH_REGS_SVH
`define CORE_FETCH_REGS_SVH

// ***************************************************************
// Widths and sizes
// ***************************************************************
`define PC_WIDTH      13
`define INSTR_WIDTH   14
`define DATA_WIDTH    8
`define STACK_DEPTH   8
`define STACK_PTR_W   3
`define PROG_ADDR_W_SMALL 10
`define PROG_ADDR_W_LARGE 11

// ***************************************************************
// Vectors and reset values
// ***************************************************************
`define RESET_VECTOR  13'h0000
`define IRQ_VECTOR    13'h0004
`define NOP_WORD      14'h0000

`endif

//--- core_fetch_pkg.sv
/*
  Types of the fetch and pipeline sequencer: phase states and carriers.
  Assumes core_fetch_regs.svh is on the include path.
*/
`default_nettype none
`include "core_fetch_regs.svh"

package core_fetch_pkg;

  // ***************************************************************
  // Phase states, Gray coded along the ring
  // ***************************************************************
  typedef enum logic [1:0] {
    PHASE_ONE   = 2'b00,
    PHASE_TWO   = 2'b01,
    PHASE_THREE = 2'b11,
    PHASE_FOUR  = 2'b10
  } phase_t;

  // ***************************************************************
  // Flow change request from the execute stage
  // ***************************************************************
  typedef struct packed {
    logic                   jump;
    logic                   call;
    logic                   ret;
    logic                   irq;
    logic [`PC_WIDTH-1:0]   target;
  } flow_req_t;

  // Data memory strobes for the executing word
  typedef struct packed {
    logic rd;
    logic wr;
  } data_strobe_t;

endpackage

`default_nettype wire

//--- core_fetch_pipeline_sequencer.sv
/*
  Fetch and pipeline sequencer of a small 8-bit Harvard core: phase ring,
  program counter, prefetch and instruction registers, return stack.
  Assumes a synchronous program memory answering within one phase, and an
  execute stage that raises flow requests during phase_four only.
*/
// Operation
// - Divide oscillator by four into four non-overlapping phases per cycle.
// - Increment PC in phase_one; latch fetched word in phase_four.
// - Load prefetched word into instruction register in phase_one; execute after.
// - Read data operand in phase_two; write result in phase_four.
// - Fetch next word while executing current; one instruction per cycle.
// - Flow changes take two cycles; prefetched word is discarded.
// - Program counter is 13 bits, spanning 8K words of 14 bits.
// - Implemented memory ends at 03FFh or 07FFh, chosen by parameter.
// - Addresses above implemented memory wrap; upper bits ignored.
// - Execution starts at 0000h after reset; interrupts go to 0004h.
// - Separate 14-bit instruction and 8-bit data paths, same cycle.
// - Return stack eight levels deep for calls and interrupts.
// - Program counter clears to zero on any reset.
// - Stack is circular, no overflow or underflow flags.
`timescale 1ns/1ps
`default_nettype none
`include "core_fetch_regs.svh"

module core_fetch_pipeline_sequencer #(
  parameter bit LARGE_MEMORY = 1'b0
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire core_fetch_pkg::flow_req_t flow_req,
  input  wire logic [`INSTR_WIDTH-1:0]   prog_rdata,
  output logic [`PC_WIDTH-1:0]           prog_addr,
  output logic [`INSTR_WIDTH-1:0]        instr_reg,
  output logic                           instr_valid,
  output logic [1:0]                     phase_code,
  output logic                           phase_one,
  output logic                           phase_two,
  output logic                           phase_three,
  output logic                           phase_four,
  output core_fetch_pkg::data_strobe_t   data_strobe,
  output logic [`PC_WIDTH-1:0]           pc
);

  // ***************************************************************
  // Local sizes
  // ***************************************************************
  // Implemented size by parameter
  localparam int ADDR_W = LARGE_MEMORY ? `PROG_ADDR_W_LARGE
                                       : `PROG_ADDR_W_SMALL;

  core_fetch_pkg::phase_t phase;
  core_fetch_pkg::phase_t next_phase;
  logic [`INSTR_WIDTH-1:0] prefetch;
  logic                    prefetch_valid;
  logic [`PC_WIDTH-1:0]    stack_mem [`STACK_DEPTH];
  logic [`STACK_PTR_W-1:0] stack_ptr;

  // Checks below run on the core clock and sleep through reset
  default clocking chk_clk @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ***************************************************************
  // Phase ring decode
  // ***************************************************************
  // Divide by four
  always_comb begin
    unique case (phase)
      core_fetch_pkg::PHASE_ONE:   next_phase = core_fetch_pkg::PHASE_TWO;
      core_fetch_pkg::PHASE_TWO:   next_phase = core_fetch_pkg::PHASE_THREE;
      core_fetch_pkg::PHASE_THREE: next_phase = core_fetch_pkg::PHASE_FOUR;
      core_fetch_pkg::PHASE_FOUR:  next_phase = core_fetch_pkg::PHASE_ONE;
    endcase
  end

  wire in_one  = (phase == core_fetch_pkg::PHASE_ONE);
  wire in_four = (phase == core_fetch_pkg::PHASE_FOUR);

  // Flow requests only count at the end of a cycle
  wire take_jump = in_four & flow_req.jump;
  wire take_call = in_four & flow_req.call;
  wire take_ret  = in_four & flow_req.ret;
  wire take_irq  = in_four & flow_req.irq;
  wire redirect  = take_jump | take_call | take_ret | take_irq;

  wire [`STACK_PTR_W-1:0] pop_ptr = stack_ptr - `STACK_PTR_W'(1);

  // Return address: pc has already stepped past the word being fetched
  wire [`PC_WIDTH-1:0] push_pc = pc - `PC_WIDTH'(1);

  // Interrupt vector, return and jump targets
  wire [`PC_WIDTH-1:0] redirect_pc =
    take_irq ? `IRQ_VECTOR :
    take_ret ? stack_mem[pop_ptr] :
               flow_req.target;

  wire [`PC_WIDTH-1:0] next_pc =
    redirect ? redirect_pc :
    in_one   ? pc + `PC_WIDTH'(1) :
               pc;

  wire [`PC_WIDTH-1:0] wrapped_addr =
    {{(`PC_WIDTH-ADDR_W){1'b0}}, pc[ADDR_W-1:0]};

  // ***************************************************************
  // Phase ring and program counter
  // ***************************************************************
  // Reset parks ring at phase_one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= core_fetch_pkg::PHASE_ONE;
    end else begin
      phase <= next_phase;
    end
  end

  // PC clears on reset; 13-bit counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= `RESET_VECTOR;
    end else begin
      pc <= next_pc;
    end
  end

  // ***************************************************************
  // Prefetch and instruction registers
  // ***************************************************************
  // Latch word in phase_four; discard it on a redirect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prefetch       <= `NOP_WORD;
      prefetch_valid <= 1'b0;
    end else if (in_four) begin
      prefetch       <= redirect ? `NOP_WORD : prog_rdata;
      prefetch_valid <= ~redirect;
    end
  end

  // Execute register loads in phase_one; overlap with fetch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_reg   <= `NOP_WORD;
      instr_valid <= 1'b0;
    end else if (in_one) begin
      instr_reg   <= prefetch;
      instr_valid <= prefetch_valid;
    end
  end

  // ***************************************************************
  // Return stack
  // ***************************************************************
  // Eight entries; pointer wraps silently
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_ptr <= '0;
    end else if (take_call | take_irq) begin
      stack_ptr <= stack_ptr + `STACK_PTR_W'(1);
    end else if (take_ret) begin
      stack_ptr <= pop_ptr;
    end
  end

  // Push the word being fetched, so the discarded word is refetched
  // after the return; entries need no reset, the pointer guards them
  always_ff @(posedge clk) begin
    if (take_call | take_irq) begin
      stack_mem[stack_ptr] <= push_pc;
    end
  end

  // ***************************************************************
  // Registered outputs
  // ***************************************************************
  // Data strobes and separate address path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_code  <= 2'h0;
      phase_one   <= 1'b1;
      phase_two   <= 1'b0;
      phase_three <= 1'b0;
      phase_four  <= 1'b0;
      data_strobe <= '0;
      prog_addr   <= `RESET_VECTOR;
    end else begin
      phase_code  <= next_phase;
      phase_one   <= (next_phase == core_fetch_pkg::PHASE_ONE);
      phase_two   <= (next_phase == core_fetch_pkg::PHASE_TWO);
      phase_three <= (next_phase == core_fetch_pkg::PHASE_THREE);
      phase_four  <= (next_phase == core_fetch_pkg::PHASE_FOUR);
      // Read strobe rises with the new word, so use what is being loaded
      data_strobe.rd <= (next_phase == core_fetch_pkg::PHASE_TWO)
                        & prefetch_valid;
      data_strobe.wr <= (next_phase == core_fetch_pkg::PHASE_FOUR)
                        & instr_valid;
      // Fetch address taken before the phase_one step lands
      if (in_one) begin
        prog_addr <= wrapped_addr;
      end
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  chk_phase_ring: assert property (
    phase_one |=> phase_two ##1 phase_three ##1 phase_four ##1 phase_one)
    else $error("phase ring out of order");

  chk_phase_onehot: assert property (
    $onehot({phase_one, phase_two, phase_three, phase_four}))
    else $error("phases overlap");

  chk_code_match: assert property (
    phase_code == phase)
    else $error("phase code disagrees with ring");

  chk_pc_step: assert property (
    (in_one && !redirect) |=> pc == $past(pc) + `PC_WIDTH'(1))
    else $error("pc did not step in phase_one");

  chk_pc_hold: assert property (
    (!in_one && !redirect) |=> $stable(pc))
    else $error("pc moved outside phase_one");

  chk_addr_hold: assert property (
    !in_one |=> $stable(prog_addr))
    else $error("fetch address moved mid cycle");

  chk_fetch_latch: assert property (
    (in_four && !redirect) |=> prefetch == $past(prog_rdata))
    else $error("fetched word not latched in phase_four");

  chk_ir_load: assert property (
    in_one |=> instr_reg == $past(prefetch))
    else $error("instruction register missed prefetch");

  chk_ir_stands: assert property (
    !in_one |=> $stable(instr_reg) && $stable(instr_valid))
    else $error("instruction register changed mid cycle");

  chk_rd_strobe: assert property (
    data_strobe.rd |-> phase_two && instr_valid)
    else $error("operand read outside phase_two");

  chk_rd_every: assert property (
    (phase_two && instr_valid) |-> data_strobe.rd)
    else $error("operand read missing in phase_two");

  chk_wr_strobe: assert property (
    data_strobe.wr |-> phase_four && instr_valid)
    else $error("result write outside phase_four");

  chk_wr_every: assert property (
    (phase_four && instr_valid) |-> data_strobe.wr)
    else $error("result write missing in phase_four");

  chk_flush_slot: assert property (
    redirect |=> ##1 !instr_valid [*4])
    else $error("prefetched word not discarded");

  chk_fetch_flush: assert property (
    redirect |=> !prefetch_valid)
    else $error("prefetch kept across a redirect");

  chk_call_target: assert property (
    ((take_jump || take_call) && !take_irq && !take_ret)
      |=> pc == $past(flow_req.target))
    else $error("branch target not loaded");

  chk_irq_vector: assert property (
    take_irq |=> pc == `IRQ_VECTOR)
    else $error("interrupt did not vector");

  chk_addr_wrap: assert property (
    prog_addr[`PC_WIDTH-1:ADDR_W] == '0)
    else $error("address not wrapped");

  chk_addr_follow: assert property (
    in_one |=> prog_addr[ADDR_W-1:0] == $past(pc[ADDR_W-1:0]))
    else $error("fetch address lost low pc bits");

  // A taken call costs two cycles, so the return lands eight clocks on
  chk_stack_ret: assert property (
    (take_call && !take_irq) ##8 (take_ret && !take_irq && !take_call)
      |=> pc == $past(pc, 9) - `PC_WIDTH'(1))
    else $error("return address lost");

  chk_push_step: assert property (
    (take_call || take_irq) |=> stack_ptr == $past(stack_ptr) + 3'h1)
    else $error("push did not advance the stack");

  chk_pop_step: assert property (
    (take_ret && !take_call && !take_irq)
      |=> stack_ptr == $past(stack_ptr) - 3'h1)
    else $error("pop did not step the stack back");

  // Main scenarios: branch, call and return, interrupt, stack wrap
  cov_branch: cover property (take_jump);
  cov_call_ret: cover property (take_call ##8 take_ret);
  cov_irq: cover property (take_irq);
  cov_stack_wrap: cover property (
    take_call && stack_ptr == `STACK_PTR_W'(7));

endmodule
`default_nettype wire

//--- prog_mem_model.sv
/*
  Program memory model that faces the fetch sequencer.
  Assumes the word is sampled at the edge that ends phase_four.
*/
`timescale 1ns/1ps
`default_nettype none

module prog_mem_model #(
  parameter int AW = 10
) (
  input  wire logic [12:0] addr,
  output logic      [13:0] rdata
);
  // ****************
  // Contents
  // ****************
  // Each word carries its own address, so a stale or wrong fetch shows
  // only the implemented address bits are decoded
  assign rdata = 14'h2000 | 14'(addr[AW-1:0]);
endmodule

`default_nettype wire

//--- core_fetch_pipeline_sequencer_test.sv
/*
  Self-checking bench of the fetch and pipeline sequencer.
  Assumes the small memory variant and the prog_mem_model partner.
*/
`timescale 1ns/1ps
`default_nettype none

module core_fetch_pipeline_sequencer_test;
  logic                          clk;
  logic                          rst_n;
  core_fetch_pkg::flow_req_t     flow_req;
  logic [13:0]                   prog_rdata;
  logic [12:0]                   prog_addr;
  logic [13:0]                   instr_reg;
  logic                          instr_valid;
  logic [1:0]                    phase_code;
  logic                          phase_one;
  logic                          phase_two;
  logic                          phase_three;
  logic                          phase_four;
  core_fetch_pkg::data_strobe_t  data_strobe;
  logic [12:0]                   pc;
  int                            miscompares;
  int                            n_checks;

  // ****************
  // Design and partner
  // ****************
  core_fetch_pipeline_sequencer #(.LARGE_MEMORY(1'b0)) uut (
    .clk(clk), .rst_n(rst_n), .flow_req(flow_req),
    .prog_rdata(prog_rdata), .prog_addr(prog_addr),
    .instr_reg(instr_reg), .instr_valid(instr_valid),
    .phase_code(phase_code), .phase_one(phase_one),
    .phase_two(phase_two), .phase_three(phase_three),
    .phase_four(phase_four), .data_strobe(data_strobe), .pc(pc)
  );
  prog_mem_model #(.AW(10)) mem (.addr(prog_addr), .rdata(prog_rdata));

  // Clock at 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ****************
  // Helpers
  // ****************
  function automatic logic [13:0] word(input logic [12:0] a);
    return 14'h2000 | 14'(a[9:0]);
  endfunction

  // Kind bits: jump, call, ret, irq
  function automatic core_fetch_pkg::flow_req_t mk(input logic [3:0] k,
                                                   input logic [12:0] t);
    return core_fetch_pkg::flow_req_t'({k, t});
  endfunction

  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic complete_run;
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Reset for 20 clocks, state checked while held
  task automatic do_reset;
    @(posedge clk) rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    check(pc === 13'h0 && phase_one === 1'b1 && instr_valid === 1'b0
          && prog_addr === 13'h0, "reset state");
    rst_n <= 1'b1;
  endtask

  // Waits for the next valid word, counting empty slots, then offers
  // a request from phase_three on; only phase_four may take it
  task automatic next_instr(input logic [12:0] a, input int skips,
                            input core_fetch_pkg::flow_req_t r);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      if (phase_two === 1'b1) n++;
    end while (!(phase_two === 1'b1 && instr_valid === 1'b1) && n < 9);
    check(n - 1 == skips, "empty slot count");
    check(instr_reg === word(a), "executed word");
    check(data_strobe.rd === 1'b1, "operand read strobe");
    @(posedge clk) flow_req <= r;
    @(posedge clk);
    @(negedge clk);
    check(phase_four === 1'b1 && data_strobe.wr === 1'b1,
          "write strobe");
    check(prog_addr[12:10] === 3'h0, "upper address bits");
    @(posedge clk) flow_req <= '0;
  endtask

  // Eight clocks of the phase ring from phase_one
  task automatic ring;
    logic [1:0] g [4];
    g = '{2'b00, 2'b01, 2'b11, 2'b10};
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      check({phase_one, phase_two, phase_three, phase_four}
            === 4'b1000 >> (i % 4) && phase_code === g[i % 4], "ring");
    end
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    rst_n = 1'b0;
    flow_req = '0;
    miscompares = 0;
    n_checks = 0;
    do_reset;
    next_instr(13'h0, 1, '0);
    next_instr(13'h1, 0, '0);
    ring;
    next_instr(13'h4, 0, mk(4'b1000, 13'h1c05));
    next_instr(13'h5, 1, mk(4'b0100, 13'h100));
    // Nine calls overfill the eight-deep stack
    for (int k = 0; k < 9; k++) begin
      next_instr(13'h100 + 13'(16 * k), 1,
                 k < 8 ? mk(4'b0100, 13'h110 + 13'(16 * k))
                       : mk(4'b0010, 13'h0));
    end
    for (int k = 7; k >= 0; k--) begin
      next_instr(13'h101 + 13'(16 * k), 1, mk(4'b0010, 13'h0));
    end
    next_instr(13'h171, 1, mk(4'b0001, 13'h0));
    next_instr(13'h4, 1, '0);
    do_reset;
    next_instr(13'h0, 1, '0);
    complete_run;
  end

  // Watchdog well beyond the expected run
  initial begin
    #1_000_000;
    miscompares++;
    complete_run;
  end
endmodule

`default_nettype wire
